/* shared/dts_consts.vh */
// Constants for the debug trigger and status register block.
`ifndef DTS_CONSTS_VH
`define DTS_CONSTS_VH
`define DTS_ADDR_W          2
`define DTS_OFF_CONTROL     2'h0
`define DTS_OFF_TRIGGER     2'h1
`define DTS_OFF_STATUS      2'h2
`define DTS_CTL_MODULE_EN   7
`define DTS_CTL_RUN_EN      6
`define DTS_TRG_TYPE        7
`define DTS_TRG_BEGIN       6
`define DTS_TRG_MODE_HI     3
`define DTS_ST_AF           7
`define DTS_ST_BF           6
`define DTS_ST_ARMED        5
`define DTS_TRG_WR_MASK     8'hcf
`define DTS_CTL_RESET       8'h00
`define DTS_TRG_RESET       8'h00
`define DTS_M_A_ONLY        4'h0
`define DTS_M_A_OR_B        4'h1
`define DTS_M_A_THEN_B      4'h2
`define DTS_M_EV_B          4'h3
`define DTS_M_A_THEN_EV_B   4'h4
`define DTS_M_A_AND_B       4'h5
`define DTS_M_A_NOT_B       4'h6
`define DTS_M_INSIDE        4'h7
`define DTS_M_OUTSIDE       4'h8
`define DTS_FIFO_DEPTH      4'h8
`endif

/* core/dts_trig_decode.v */
// Trigger mode decoder: turns qualified comparator matches into a trigger event.
`timescale 1ns/100ps
module dts_trig_decode (
    // Setup.
    input  wire [3:0] mode,
    input  wire       a_seen,
    // Qualified matches this cycle.
    input  wire       hit_a,
    input  wire       hit_b,
    input  wire       in_range,
    // Results.
    output reg        trigger,
    output reg        event_only
);
    `include "dts_consts.vh"
    always @* begin
        trigger    = 1'b0;
        event_only = 1'b0;
        case (mode)
            `DTS_M_A_ONLY:      trigger = hit_a;
            `DTS_M_A_OR_B:      trigger = hit_a | hit_b;
            `DTS_M_A_THEN_B:    trigger = a_seen & hit_b;
            `DTS_M_EV_B: begin
                trigger    = hit_b;
                event_only = 1'b1;
            end
            `DTS_M_A_THEN_EV_B: begin
                trigger    = a_seen & hit_b;
                event_only = 1'b1;
            end
            `DTS_M_A_AND_B:     trigger = hit_a & hit_b;
            `DTS_M_A_NOT_B:     trigger = hit_a & ~hit_b;
            `DTS_M_INSIDE:      trigger = in_range;
            `DTS_M_OUTSIDE:     trigger = ~in_range;
            default:            trigger = 1'b0;
        endcase
    end
endmodule // dts_trig_decode

/* core/dts_valid_count.v */
// Counter of valid capture words, saturating at the FIFO depth.
`timescale 1ns/100ps
module dts_valid_count #(
    parameter [3:0] DEPTH = 4'h8
) (
    // Clock and reset.
    input  wire       core_clk,
    input  wire       rst,
    // Control.
    input  wire       clear,
    input  wire       store,
    // Result.
    output reg  [3:0] count_q,
    output wire       full
);
    assign full = (count_q == DEPTH);
    // Reading words out never touches the count; the host keeps its own tally.
    always @(posedge core_clk) begin
        if (rst) begin
            count_q <= 4'h0;
        end else if (clear) begin
            count_q <= 4'h0;
        end else if (store && !full) begin
            count_q <= count_q + 4'h1;
        end
    end
endmodule // dts_valid_count

/* core/dts_debug_regs.v */
// Debug trigger setup, status and run control registers.
`timescale 1ns/100ps
module dts_debug_regs (
    // Clock and reset.
    input  wire       core_clk,
    input  wire       rst,
    // Register port.
    input  wire [1:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata_q,
    // Comparator side.
    input  wire       match_a,
    input  wire       match_b,
    input  wire       in_range,
    input  wire       opcode_exec_a,
    input  wire       opcode_exec_b,
    // Capture side.
    input  wire       capture_word,
    input  wire       fifo_full,
    // Outputs to the datapath.
    output reg        capture_en_q,
    output reg        circular_q,
    output reg        high_byte_zero_q,
    output reg        trigger_q,
    output reg        armed_q
);
    `include "dts_consts.vh"

    ////////////////////////////////////////////////////////////////////////////////
    reg  [7:0] control_q;
    reg  [7:0] trigger_setup_q;
    reg        flag_a_q;
    reg        flag_b_q;
    reg        a_seen_q;
    reg        triggered_q;
    wire       hit_a;
    wire       hit_b;
    wire       trig_now;
    wire       event_only;
    wire       begin_trace;
    wire       arm_write;
    wire       ctl_write;
    wire       complete;
    wire       store;
    wire [3:0] valid_count;
    wire       count_full;

    // Tag type lets a match through only when its opcode really executes.
    assign hit_a = trigger_setup_q[`DTS_TRG_TYPE] ? (match_a & opcode_exec_a) : match_a;
    assign hit_b = trigger_setup_q[`DTS_TRG_TYPE] ? (match_b & opcode_exec_b) : match_b;

    dts_trig_decode u_decode (
        .mode       (trigger_setup_q[`DTS_TRG_MODE_HI:0]),
        .a_seen     (a_seen_q | hit_a),
        .hit_a      (hit_a),
        .hit_b      (hit_b),
        .in_range   (in_range),
        .trigger    (trig_now),
        .event_only (event_only)
    );

    assign begin_trace = event_only | trigger_setup_q[`DTS_TRG_BEGIN];
    assign ctl_write   = reg_wr && (reg_addr == `DTS_OFF_CONTROL);
    assign arm_write   = ctl_write && reg_wdata[`DTS_CTL_RUN_EN]
                         && reg_wdata[`DTS_CTL_MODULE_EN];
    // A begin trace stores from the trigger cycle on; an end trace stores from arming.
    assign store       = armed_q && capture_word && (!begin_trace || triggered_q || trig_now);
    assign complete    = armed_q && (begin_trace ? (fifo_full | count_full)
                                                 : trig_now);

    dts_valid_count #(
        .DEPTH (`DTS_FIFO_DEPTH)
    ) u_count (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (arm_write),
        .store    (store && !arm_write),
        .count_q  (valid_count),
        .full     (count_full)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        if (rst) begin
            control_q       <= `DTS_CTL_RESET;
            trigger_setup_q <= `DTS_TRG_RESET;
        end else begin
            if (ctl_write) begin
                control_q <= reg_wdata;
            end else if (complete) begin
                control_q[`DTS_CTL_RUN_EN] <= 1'b0;
            end
            if (reg_wr && (reg_addr == `DTS_OFF_TRIGGER) && !control_q[`DTS_CTL_RUN_EN]) begin
                trigger_setup_q <= reg_wdata & `DTS_TRG_WR_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The armed state follows the run enable exactly while the module is enabled.
    always @(posedge core_clk) begin
        if (rst) begin
            armed_q     <= 1'b0;
            flag_a_q    <= 1'b0;
            flag_b_q    <= 1'b0;
            a_seen_q    <= 1'b0;
            triggered_q <= 1'b0;
        end else if (arm_write) begin
            armed_q     <= 1'b1;
            flag_a_q    <= 1'b0;
            flag_b_q    <= 1'b0;
            a_seen_q    <= 1'b0;
            triggered_q <= 1'b0;
        end else begin
            if (ctl_write) begin
                armed_q <= reg_wdata[`DTS_CTL_RUN_EN] & reg_wdata[`DTS_CTL_MODULE_EN];
            end else if (complete) begin
                armed_q <= 1'b0;
            end
            if (armed_q && hit_a) begin
                flag_a_q <= 1'b1;
                a_seen_q <= 1'b1;
            end
            if (armed_q && hit_b) begin
                flag_b_q <= 1'b1;
            end
            if (armed_q && trig_now) begin
                triggered_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        if (rst) begin
            capture_en_q     <= 1'b0;
            circular_q       <= 1'b0;
            high_byte_zero_q <= 1'b0;
            trigger_q        <= 1'b0;
        end else begin
            capture_en_q     <= store;
            circular_q       <= ~begin_trace;
            high_byte_zero_q <= event_only;
            trigger_q        <= armed_q & trig_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Writes to the status offset fall through with no decode, so they change nothing.
    always @(posedge core_clk) begin
        if (rst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `DTS_OFF_CONTROL: reg_rdata_q <= control_q;
                `DTS_OFF_TRIGGER: reg_rdata_q <= trigger_setup_q;
                `DTS_OFF_STATUS:  reg_rdata_q <= {flag_a_q, flag_b_q,
                                                  armed_q & control_q[`DTS_CTL_MODULE_EN],
                                                  1'b0, valid_count};
                default:          reg_rdata_q <= 8'h00;
            endcase
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end
endmodule // dts_debug_regs

/* tb/dts_fifo_model.sv */
// Capture FIFO stand-in that counts stored words and flags full.
`timescale 1ns/100ps
module dts_fifo_model (
    // Clock.
    input  wire  core_clk,
    // From the block.
    input  wire  armed_q,
    input  wire  capture_en_q,
    // To the block.
    output logic fifo_full
);
    int fill = 0;
    // The far side keeps its own word count, since the block's count only clears on an arming write.
    always @(posedge core_clk) begin
        if (!armed_q) begin
            fill <= 0;
        end else if (capture_en_q && fill < 8) begin
            fill <= fill + 1;
        end
    end
    assign fifo_full = (fill == 8);
endmodule // dts_fifo_model

/* tb/dts_debug_regs_props.sv */
// Port checks for the debug trigger and status registers.
`timescale 1ns/100ps
module dts_debug_regs_props (
    // Clock and reset.
    input wire       core_clk,
    input wire       rst,
    // Register port.
    input wire [1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata_q,
    // Run side.
    input wire       fifo_full,
    input wire       capture_en_q,
    input wire       circular_q,
    input wire       trigger_q,
    input wire       armed_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_arm_wr;
        reg_wr && reg_addr == 2'h0 && reg_wdata[7:6] == 2'b11;
    endsequence
    sequence s_stat_rd;
        reg_rd && reg_addr == 2'h2;
    endsequence
    chk_arm_sets: assert property (s_arm_wr |=> armed_q) else $error("arm lost");
    chk_arm_clears: assert property (s_arm_wr ##[1:2] s_stat_rd |=>
        reg_rdata_q[7:6] == 2'b00 && reg_rdata_q[3:0] == 4'h0) else $error("arm kept flags");
    chk_stop_run: assert property (reg_wr && reg_addr == 2'h0 && !(&reg_wdata[7:6])
        |=> !armed_q) else $error("stop ignored");
    chk_full_ends: assert property (armed_q && fifo_full && !circular_q
        |-> ##[1:2] !armed_q) else $error("full run kept");
    chk_trig_ends: assert property (trigger_q && circular_q
        |-> !armed_q) else $error("end trace kept");
    chk_trg_zero: assert property (reg_rd && reg_addr == 2'h1
        |=> reg_rdata_q[5:4] == 2'b00) else $error("fixed bits set");
    chk_armed_read: assert property (s_stat_rd
        |=> reg_rdata_q[5] == $past(armed_q)) else $error("armed bit wrong");
    chk_trig_gated: assert property (trigger_q |-> $past(armed_q)) else $error("idle trig");
    chk_store_gated: assert property (capture_en_q
        |-> $past(armed_q) || $past(armed_q, 2)) else $error("idle store");
endmodule // dts_debug_regs_props
////////////////////////////////////////
bind dts_debug_regs dts_debug_regs_props chk_u (.core_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata_q, .fifo_full, .capture_en_q, .circular_q, .trigger_q,
    .armed_q);

/* tb/dts_debug_regs_tb_top.sv */
// Self-checking bench for the debug trigger and status registers.
`timescale 1ns/100ps
module dts_debug_regs_tb_top;
    logic       core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
    logic [1:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata_q;
    logic       match_a = 0, match_b = 0, in_range = 0, capture_word = 0;
    logic       opcode_exec_a = 0, opcode_exec_b = 0;
    logic       capture_en_q, circular_q, high_byte_zero_q, trigger_q, armed_q;
    wire        fifo_full;
    logic [15:0] ends_map = 16'h01a7;
    int         num_errors = 0, checks = 0, cycles = 0, m;
    always #20 core_clk = ~core_clk;
    dts_debug_regs dut_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata_q, .match_a, .match_b, .in_range, .opcode_exec_a, .opcode_exec_b,
        .capture_word, .fifo_full, .capture_en_q, .circular_q, .high_byte_zero_q,
        .trigger_q, .armed_q);
    dts_fifo_model fifo_u (.core_clk, .armed_q, .capture_en_q, .fifo_full);
    ////////////////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge core_clk);
        reg_wr <= 0;
    endtask
    task rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge core_clk);
        reg_rd <= 0;
        #1 chk(reg_rdata_q, e);
    endtask
    task close_out;
        $display("checks %0d, num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            close_out;
        end
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(24034));
        repeat (8) @(posedge core_clk);
        rst <= 0;
        for (m = 0; m < 4; m++) rd(m[1:0], 8'h00);
        reg_wdata = 8'($urandom);
        wr(2'h1, reg_wdata);
        rd(2'h1, reg_wdata & 8'hcf);
        wr(2'h2, 8'hff);
        rd(2'h2, 8'h00);
        $display("test registers done");
        for (m = 0; m < 16; m++) begin
            // Outside-range mode triggers on any access outside A..B, so idle inside the range.
            in_range <= (m == 8);
            wr(2'h1, 8'(m));
            wr(2'h0, 8'hc0);
            rd(2'h2, 8'h20);
            chk({7'h0, circular_q}, {7'h0, m != 3 && m != 4});
            chk({7'h0, high_byte_zero_q}, {7'h0, m == 3 || m == 4});
            wr(2'h1, 8'($urandom));
            rd(2'h1, 8'(m));
            @(posedge core_clk);
            {match_a, match_b, in_range} <= {2'b11, m != 8};
            repeat (4) @(posedge core_clk);
            {match_a, match_b, in_range} <= {2'b00, m == 8};
            @(negedge core_clk);
            chk(armed_q, {7'h0, ~ends_map[m]});
            wr(2'h0, 8'h80);
            @(negedge core_clk);
            chk(armed_q, 8'h00);
        end
        $display("test modes done");
        wr(2'h1, 8'h80);
        wr(2'h0, 8'hc0);
        @(posedge core_clk);
        match_a <= 1;
        repeat (4) @(posedge core_clk);
        {opcode_exec_a, opcode_exec_b} <= 2'h3;
        @(negedge core_clk);
        chk(armed_q, 8'h01);
        repeat (4) @(posedge core_clk);
        {match_a, opcode_exec_a, opcode_exec_b} <= 3'h0;
        @(negedge core_clk);
        chk(armed_q, 8'h00);
        $display("test tag done");
        wr(2'h1, 8'h40);
        wr(2'h0, 8'hc0);
        @(posedge core_clk);
        capture_word <= 1;
        repeat (4) @(posedge core_clk);
        match_a <= 1;
        @(negedge core_clk);
        chk({armed_q, circular_q, capture_en_q}, 8'h04);
        repeat (16) @(posedge core_clk);
        {capture_word, match_a} <= 2'h0;
        rd(2'h2, 8'h88);
        rd(2'h2, 8'h88);
        wr(2'h0, 8'hc0);
        rd(2'h2, 8'h20);
        wr(2'h0, 8'h40);
        rd(2'h2, 8'h00);
        $display("test fill done");
        close_out;
    end
endmodule // dts_debug_regs_tb_top
